/* pkg/nvs_pkg.sv */
package nvs_pkg;

    localparam int CLK_PERIOD_NS      = 5;
    localparam int ADDR_W             = 15;
    localparam int DATA_W             = 8;
    localparam int SYNC_STAGES        = 2;
    localparam int CNT_W              = 32;

    // pin timing of the slowest speed grade, all least times
    localparam int READ_ACCESS_NS     = 45;
    localparam int WRITE_PULSE_NS     = 30;
    localparam int BUS_TURN_NS        = 15;
    localparam int HSB_PULSE_NS       = 15;
    localparam int ACCESS_DELAY_NS    = 1000;
    localparam int BUSY_ONSET_NS      = 300;
    localparam int RECOVER_NS         = 700;
    localparam int POWERUP_RECALL_US  = 550;
    localparam int SOFTWARE_RECALL_US = 550;
    localparam int STORE_CYCLE_MS     = 10;

    localparam int READ_ACCESS_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_TURN_CYC       = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HSB_PULSE_CYC      = (HSB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HSB_WAIT_CYC       = (ACCESS_DELAY_NS + BUSY_ONSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC        = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_RECALL_CYC = (POWERUP_RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_RECALL_CYC      = (SOFTWARE_RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_CYCLE_CYC    = (STORE_CYCLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [ADDR_W-1:0] SEQ_ADDR_0    = 15'h0E38;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_1    = 15'h31C7;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_2    = 15'h03E0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_3    = 15'h3C1F;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_4    = 15'h303F;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_STO  = 15'h0FC0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_RCL  = 15'h0C63;
    localparam logic [2:0]        SEQ_LAST      = 3'h5;

    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_WRITE     = 3'b001,
        OP_SW_STORE  = 3'b010,
        OP_SW_RECALL = 3'b011,
        OP_HW_STORE  = 3'b100
    } nvs_op_t;

    typedef enum logic [3:0] {
        ST_POWERUP  = 4'b0000,
        ST_IDLE     = 4'b0001,
        ST_ACCESS   = 4'b0010,
        ST_GAP      = 4'b0011,
        ST_NV_WAIT  = 4'b0100,
        ST_HS_PULSE = 4'b0101,
        ST_HS_DELAY = 4'b0110,
        ST_HS_BUSY  = 4'b0111,
        ST_RECOVER  = 4'b1000
    } nvs_state_t;

    typedef struct packed {
        nvs_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nvs_cmd_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_en_n;
        logic [ADDR_W-1:0] byte_address;
    } nvs_pins_t;

    localparam nvs_pins_t PINS_IDLE = '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
                                        byte_address: '0};

endpackage : nvs_pkg

/* hdl/nvs_host.sv */
`timescale 1ns/1ps
// Contract
// - address set before write starts, held until chip-select or write-enable rises; here it is set on the same clock edge as write-enable falls.
// - output-enable kept high through every write.
// - software store: reads at 0E38,31C7,03E0,3C1F,303F,0FC0 in that order.
// - sequence uses chip-select controlled reads; output-enable may stay high.
// - software recall: same five reads then 0C63.
module nvs_host
    import nvs_pkg::*;
#(
    parameter int unsigned POWERUP_RECALL_CYCLES = nvs_pkg::POWERUP_RECALL_CYC,
    parameter int unsigned SW_RECALL_CYCLES      = nvs_pkg::SW_RECALL_CYC,
    parameter int unsigned STORE_CYCLES          = nvs_pkg::STORE_CYCLE_CYC
)
(
    input  wire logic                      clock_in,
    input  wire logic                      rst_in,
    input  wire logic                      cmd_valid_in,
    output logic                           cmd_ready_out,
    input  wire nvs_pkg::nvs_cmd_t         cmd_in,
    output logic                           rsp_valid_out,
    output logic [nvs_pkg::DATA_W-1:0]     rsp_data_out,
    output logic                           modified_out,
    output nvs_pkg::nvs_pins_t             pins_out,
    input  wire logic [nvs_pkg::DATA_W-1:0] shared_data_lines_in,
    output logic [nvs_pkg::DATA_W-1:0]     shared_data_lines_out,
    output logic                           shared_data_lines_oe_out,
    input  wire logic                      hw_store_busy_n_in,
    output logic                           hw_store_busy_n_out,
    output logic                           hw_store_busy_n_oe_out
);
    import nvs_pkg::*;

    nvs_state_t          state_q;
    logic [CNT_W-1:0]    cnt_q;
    nvs_op_t             op_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [2:0]          seq_q;
    nvs_pins_t           pins_q;
    logic                dq_oe_q;
    logic                hsb_drive_q;
    logic                rsp_valid_q;
    logic [DATA_W-1:0]   rsp_data_q;
    logic                modified_q;
    logic                hsb_meta_q;
    logic                hsb_sync_q;
    logic [DATA_W-1:0]   dq_meta_q;
    logic [DATA_W-1:0]   dq_sync_q;
    logic                cnt_done;
    logic                accept;
    logic                is_seq;

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input nvs_op_t op);
        logic [ADDR_W-1:0] a;
        case (idx)
            3'h0:    a = SEQ_ADDR_0;
            3'h1:    a = SEQ_ADDR_1;
            3'h2:    a = SEQ_ADDR_2;
            3'h3:    a = SEQ_ADDR_3;
            3'h4:    a = SEQ_ADDR_4;
            default: a = (op == OP_SW_STORE) ? SEQ_ADDR_STO : SEQ_ADDR_RCL;
        endcase
        return a;
    endfunction : seq_addr

    assign cnt_done      = (cnt_q == '0);
    assign is_seq        = (op_q == OP_SW_STORE) || (op_q == OP_SW_RECALL);
    // no new access while the store line is low, ours or the device's
    assign cmd_ready_out = (state_q == ST_IDLE) && hsb_sync_q;
    assign accept        = cmd_valid_in && cmd_ready_out;

    assign pins_out                 = pins_q;
    assign shared_data_lines_out    = wdata_q;
    assign shared_data_lines_oe_out = dq_oe_q;
    // open drain: only ever pulls low
    assign hw_store_busy_n_out      = 1'b0;
    assign hw_store_busy_n_oe_out   = hsb_drive_q;
    assign rsp_valid_out            = rsp_valid_q;
    assign rsp_data_out             = rsp_data_q;
    assign modified_out             = modified_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            hsb_meta_q <= 1'b1;
            hsb_sync_q <= 1'b1;
            dq_meta_q  <= '0;
            dq_sync_q  <= '0;
        end
        else
        begin
            hsb_meta_q <= hw_store_busy_n_in;
            hsb_sync_q <= hsb_meta_q;
            dq_meta_q  <= shared_data_lines_in;
            dq_sync_q  <= dq_meta_q;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q     <= ST_POWERUP;
            cnt_q       <= '0;
            op_q        <= OP_READ;
            wdata_q     <= '0;
            seq_q       <= '0;
            pins_q      <= PINS_IDLE;
            dq_oe_q     <= 1'b0;
            hsb_drive_q <= 1'b0;
        end
        else
        begin
            if (cnt_q != '0)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                ST_POWERUP:
                begin
                    // first entry only: load the recall wait, then count it out
                    if (cnt_q == '0 && op_q == OP_READ && seq_q == '0 && !hsb_drive_q && !dq_oe_q)
                    begin
                        cnt_q   <= CNT_W'(POWERUP_RECALL_CYCLES - 1);
                        seq_q   <= 3'h7;
                    end
                    else if (cnt_done)
                    begin
                        seq_q   <= '0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    if (!hsb_sync_q)
                    begin
                        state_q <= ST_HS_BUSY;
                    end
                    else if (accept)
                    begin
                        op_q    <= cmd_in.op;
                        wdata_q <= cmd_in.data;
                        seq_q   <= '0;
                        case (cmd_in.op)
                            OP_READ:
                            begin
                                pins_q  <= '{chip_sel_n: 1'b0, out_en_n: 1'b0, write_en_n: 1'b1,
                                             byte_address: cmd_in.addr};
                                cnt_q   <= CNT_W'(READ_ACCESS_CYC + SYNC_STAGES - 1);
                                state_q <= ST_ACCESS;
                            end
                            OP_WRITE:
                            begin
                                // address and data set with the falling edges, output-enable high
                                pins_q  <= '{chip_sel_n: 1'b0, out_en_n: 1'b1, write_en_n: 1'b0,
                                             byte_address: cmd_in.addr};
                                dq_oe_q <= 1'b1;
                                cnt_q   <= CNT_W'(WRITE_PULSE_CYC - 1);
                                state_q <= ST_ACCESS;
                            end
                            OP_SW_STORE, OP_SW_RECALL:
                            begin
                                pins_q  <= '{chip_sel_n: 1'b0, out_en_n: 1'b1, write_en_n: 1'b1,
                                             byte_address: SEQ_ADDR_0};
                                cnt_q   <= CNT_W'(READ_ACCESS_CYC - 1);
                                state_q <= ST_ACCESS;
                            end
                            OP_HW_STORE:
                            begin
                                hsb_drive_q <= 1'b1;
                                cnt_q       <= CNT_W'(HSB_PULSE_CYC - 1);
                                state_q     <= ST_HS_PULSE;
                            end
                            default:
                            begin
                                state_q <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ACCESS:
                begin
                    if (cnt_done)
                    begin
                        // chip-select rises with write-enable so either edge ends the cycle
                        pins_q.chip_sel_n <= 1'b1;
                        pins_q.out_en_n   <= 1'b1;
                        pins_q.write_en_n <= 1'b1;
                        cnt_q             <= CNT_W'(BUS_TURN_CYC - 1);
                        state_q           <= ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    // data held one cycle past the rising edge for zero hold
                    dq_oe_q <= 1'b0;
                    if (cnt_done)
                    begin
                        if (is_seq && seq_q != SEQ_LAST)
                        begin
                            // back to back, nothing else may slip in between
                            seq_q   <= seq_q + 3'h1;
                            pins_q  <= '{chip_sel_n: 1'b0, out_en_n: 1'b1, write_en_n: 1'b1,
                                         byte_address: seq_addr(seq_q + 3'h1, op_q)};
                            cnt_q   <= CNT_W'(READ_ACCESS_CYC - 1);
                            state_q <= ST_ACCESS;
                        end
                        else if (is_seq)
                        begin
                            cnt_q   <= (op_q == OP_SW_STORE) ? CNT_W'(STORE_CYCLES - 1)
                                                             : CNT_W'(SW_RECALL_CYCLES - 1);
                            state_q <= ST_NV_WAIT;
                        end
                        else
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_NV_WAIT:
                begin
                    if (cnt_done)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HS_PULSE:
                begin
                    if (cnt_done)
                    begin
                        hsb_drive_q <= 1'b0;
                        cnt_q       <= CNT_W'(HSB_WAIT_CYC - 1);
                        state_q     <= ST_HS_DELAY;
                    end
                end
                ST_HS_DELAY:
                begin
                    if (cnt_done)
                    begin
                        state_q <= ST_HS_BUSY;
                    end
                end
                ST_HS_BUSY:
                begin
                    if (hsb_sync_q)
                    begin
                        cnt_q   <= CNT_W'(RECOVER_CYC - 1);
                        state_q <= ST_RECOVER;
                    end
                end
                ST_RECOVER:
                begin
                    if (!hsb_sync_q)
                    begin
                        state_q <= ST_HS_BUSY;
                    end
                    else if (cnt_done)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // response: one pulse per accepted command of a defined op, and one per busy entered from idle while op_q is still OP_HW_STORE; read data from the synced bus
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            if (state_q == ST_ACCESS && cnt_done && op_q == OP_READ)
            begin
                rsp_data_q <= dq_sync_q;
            end
            if ((state_q == ST_GAP && cnt_done && !is_seq)
                || (state_q == ST_NV_WAIT && cnt_done)
                || (state_q == ST_RECOVER && hsb_sync_q && cnt_done && op_q == OP_HW_STORE))
            begin
                rsp_valid_q <= 1'b1;
            end
        end
    end

    // mirror of the device's modified flag
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            modified_q <= 1'b0;
        end
        else if (state_q == ST_ACCESS && cnt_done && op_q == OP_WRITE)
        begin
            modified_q <= 1'b1;
        end
        else if ((state_q == ST_NV_WAIT && cnt_done)
                 || (state_q == ST_RECOVER && hsb_sync_q && cnt_done))
        begin
            // a skipped store leaves it clear anyway, so clearing is safe
            modified_q <= 1'b0;
        end
    end

endmodule : nvs_host

/* testbench/nvs_host_chk.sv */
`timescale 1ns/1ps
module nvs_host_chk
    import nvs_pkg::*;
(
    input  wire logic               clock_in,
    input  wire logic               rst_in,
    input  wire logic               cmd_ready_out,
    input  wire logic               rsp_valid_out,
    input  wire logic               modified_out,
    input  wire nvs_pkg::nvs_pins_t pins_out,
    input  wire logic               shared_data_lines_oe_out,
    input  wire logic               hw_store_busy_n_out,
    input  wire logic               hw_store_busy_n_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    rw_exclusive_a: assert property (pins_out.out_en_n || pins_out.write_en_n)
        else $error("read and write strobes low together");
    write_drive_a: assert property (!pins_out.write_en_n |-> shared_data_lines_oe_out)
        else $error("write strobe low without data driven");
    read_release_a: assert property (!pins_out.out_en_n |-> !shared_data_lines_oe_out)
        else $error("host drives bus during a read");
    addr_hold_a: assert property (!pins_out.chip_sel_n && $past(!pins_out.chip_sel_n)
        |-> $stable(pins_out.byte_address))
        else $error("address moved while selected");
    write_pulse_a: assert property ($fell(pins_out.write_en_n)
        |-> !pins_out.write_en_n[*6] ##1 pins_out.write_en_n)
        else $error("write pulse length wrong");
    seq_read_a: assert property ($fell(pins_out.chip_sel_n) && pins_out.out_en_n && pins_out.write_en_n
        |-> !pins_out.chip_sel_n[*8] ##1 !pins_out.chip_sel_n ##1 pins_out.chip_sel_n)
        else $error("sequence read select length wrong");
    read_len_a: assert property ($fell(pins_out.out_en_n)
        |-> !pins_out.out_en_n[*8] ##[1:6] pins_out.out_en_n)
        else $error("read strobe length wrong");
    busy_pulse_a: assert property ($rose(hw_store_busy_n_oe_out)
        |-> hw_store_busy_n_oe_out[*3] ##1 !hw_store_busy_n_oe_out)
        else $error("store line pulse length wrong");
    open_drain_a: assert property (hw_store_busy_n_out == 1'b0)
        else $error("store line driven high");
    rsp_pulse_a: assert property (rsp_valid_out |=> !rsp_valid_out)
        else $error("response longer than one cycle");
    ready_idle_a: assert property (cmd_ready_out |-> pins_out.chip_sel_n && !hw_store_busy_n_oe_out)
        else $error("ready while an access runs");
    mod_set_a: assert property ($rose(pins_out.write_en_n) |-> ##[0:12] modified_out)
        else $error("modified not set after write");
endmodule : nvs_host_chk

bind nvs_host nvs_host_chk nvs_host_chk_inst (.clock_in(clock_in), .rst_in(rst_in),
    .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .modified_out(modified_out),
    .pins_out(pins_out), .shared_data_lines_oe_out(shared_data_lines_oe_out),
    .hw_store_busy_n_out(hw_store_busy_n_out), .hw_store_busy_n_oe_out(hw_store_busy_n_oe_out));

/* testbench/nvs_mem_model.sv */
`timescale 1ns/1ps
module nvs_mem_model
    import nvs_pkg::*;
#(
    parameter int STORE_NS = 200,
    parameter int DELAY_NS = 1000
)
(
    input  wire nvs_pkg::nvs_pins_t pins_in,
    input  wire logic [7:0]         host_data_in,
    input  wire logic               host_oe_in,
    input  wire logic               host_hsb_oe_in,
    input  wire logic               power_drop_in,
    output logic [7:0]              bus_out,
    output logic                    hsb_line_out
);
    logic [7:0]  sram [0:32767];
    logic [7:0]  nvram [0:32767];
    logic [7:0]  last_q = 8'h00;
    logic [14:0] a_q;
    logic        pull = 1'b0;
    logic        busy = 1'b0;
    logic        modified = 1'b0;
    logic        wr_act = 1'b0;
    int          seq_idx = 0;
    logic [14:0] seq_tab [0:4] = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
    // released bus shows the inverse of its last value, never a stale copy
    wire drive = !pins_in.chip_sel_n && !pins_in.out_en_n && pins_in.write_en_n && hsb_line_out && !busy;
    assign hsb_line_out = !(pull || host_hsb_oe_in);
    assign bus_out = host_oe_in ? host_data_in : drive ? sram[pins_in.byte_address] : ~last_q;
    always @*
        if (host_oe_in)
            last_q = host_data_in;
        else if (drive)
            last_q = sram[pins_in.byte_address];

    task automatic nv_store();
        busy = 1'b1;
        pull = 1'b1;
        for (int i = 0; i < 32768; i++)
        begin
            nvram[i] = 8'h00;
            nvram[i] = sram[i];
        end
        #STORE_NS;
        modified = 1'b0;
        pull = 1'b0;
        wait (hsb_line_out);
        busy = 1'b0;
    endtask : nv_store

    task automatic nv_recall();
        busy = 1'b1;
        for (int i = 0; i < 32768; i++)
        begin
            sram[i] = 8'h00;
            sram[i] = nvram[i];
        end
        #50;
        modified = 1'b0;
        busy = 1'b0;
    endtask : nv_recall

    initial
    begin
        for (int i = 0; i < 32768; i++)
            nvram[i] = i[7:0] ^ 8'hA5;
        nv_recall();
    end

    always @(negedge pins_in.chip_sel_n or negedge pins_in.write_en_n)
        wr_act = !pins_in.chip_sel_n && !pins_in.write_en_n && hsb_line_out && !busy;

    always @(posedge pins_in.chip_sel_n or posedge pins_in.write_en_n)
    begin
        a_q = pins_in.byte_address;
        if (wr_act)
        begin
            sram[a_q] = host_data_in;
            modified = 1'b1;
            seq_idx = 0;
        end
        else if (pins_in.chip_sel_n && !busy && hsb_line_out)
        begin
            if (seq_idx == 5 && a_q == SEQ_ADDR_STO)
                nv_store();
            else if (seq_idx == 5 && a_q == SEQ_ADDR_RCL)
                nv_recall();
            seq_idx = (seq_idx < 5 && a_q == seq_tab[seq_idx]) ? seq_idx + 1 : int'(a_q == SEQ_ADDR_0);
        end
        wr_act = 1'b0;
    end

    always @(negedge hsb_line_out)
        if (!busy)
        begin
            #DELAY_NS;
            if (modified)
                nv_store();
        end

    always @(posedge power_drop_in)
    begin
        busy = 1'b1;
        pull = 1'b1;
        #DELAY_NS;
        if (modified)
            nv_store();
        pull = 1'b0;
        busy = 1'b0;
    end
endmodule : nvs_mem_model

/* testbench/nvs_host_tb.sv */
`timescale 1ns/1ps
module nvs_host_tb;
    import nvs_pkg::*;
    logic       clock_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       cmd_valid_in = 1'b0;
    logic       power_drop = 1'b0;
    nvs_cmd_t   cmd_in = '0;
    logic       cmd_ready_out, rsp_valid_out, modified_out, d_oe, h_out, h_oe, hsb_line;
    logic [7:0] rsp_data_out, d_out, bus;
    nvs_pins_t  pins_out;
    int         err_total = 0;
    int         tests_run = 0;

    always #2.5 clock_in = ~clock_in;

    nvs_host #(.POWERUP_RECALL_CYCLES(20), .SW_RECALL_CYCLES(20), .STORE_CYCLES(50)) nvs_host_inst (
        .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
        .cmd_in(cmd_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
        .modified_out(modified_out), .pins_out(pins_out), .shared_data_lines_in(bus),
        .shared_data_lines_out(d_out), .shared_data_lines_oe_out(d_oe), .hw_store_busy_n_in(hsb_line),
        .hw_store_busy_n_out(h_out), .hw_store_busy_n_oe_out(h_oe));
    nvs_mem_model nvs_mem_model_inst (.pins_in(pins_out), .host_data_in(d_out), .host_oe_in(d_oe),
        .host_hsb_oe_in(h_oe), .power_drop_in(power_drop), .bus_out(bus), .hsb_line_out(hsb_line));

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // bounded waits; a stuck handshake counts as a mismatch
    task automatic do_cmd(input nvs_op_t op, input logic [14:0] a, input logic [7:0] d);
        int n;
        @(negedge clock_in);
        cmd_in = '{op: op, addr: a, data: d};
        cmd_valid_in = 1'b1;
        for (n = 0; cmd_ready_out !== 1'b1 && n < 2000; n++)
            @(negedge clock_in);
        @(negedge clock_in);
        cmd_valid_in = 1'b0;
        for (n = 0; rsp_valid_out !== 1'b1 && n < 3000; n++)
            @(negedge clock_in);
        check_byte("response", 8'h01, {7'h0, rsp_valid_out});
    endtask : do_cmd

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        do_cmd(OP_READ, a, 8'h00);
        check_byte("read data", e, rsp_data_out);
    endtask : rd_chk

    task automatic t_powerup();
        rd_chk(15'h0123, 8'h86);
        check_byte("modified", 8'h00, {7'h0, modified_out});
    endtask : t_powerup

    task automatic t_rw();
        do_cmd(OP_WRITE, 15'h0000, 8'h5A);
        do_cmd(OP_WRITE, 15'h7FFF, 8'hC3);
        check_byte("modified", 8'h01, {7'h0, modified_out});
        rd_chk(15'h0000, 8'h5A);
        rd_chk(15'h7FFF, 8'hC3);
    endtask : t_rw

    task automatic t_sw();
        do_cmd(OP_SW_STORE, 15'h0000, 8'h00);
        check_byte("modified", 8'h00, {7'h0, modified_out});
        do_cmd(OP_WRITE, 15'h0000, 8'h11);
        do_cmd(OP_SW_RECALL, 15'h0000, 8'h00);
        rd_chk(15'h0000, 8'h5A);
        rd_chk(15'h7FFF, 8'hC3);
    endtask : t_sw

    task automatic t_hw();
        do_cmd(OP_WRITE, 15'h0010, 8'h77);
        do_cmd(OP_HW_STORE, 15'h0000, 8'h00);
        check_byte("modified", 8'h00, {7'h0, modified_out});
        do_cmd(OP_WRITE, 15'h0010, 8'h00);
        do_cmd(OP_SW_RECALL, 15'h0000, 8'h00);
        rd_chk(15'h0010, 8'h77);
    endtask : t_hw

    task automatic t_auto();
        do_cmd(OP_WRITE, 15'h0030, 8'h44);
        power_drop = 1'b1;
        repeat (20) @(negedge clock_in);
        check_byte("ready while busy", 8'h00, {7'h0, cmd_ready_out});
        power_drop = 1'b0;
        rd_chk(15'h0030, 8'h44);
        check_byte("modified", 8'h00, {7'h0, modified_out});
        do_cmd(OP_WRITE, 15'h0030, 8'h00);
        do_cmd(OP_SW_RECALL, 15'h0000, 8'h00);
        rd_chk(15'h0030, 8'h44);
    endtask : t_auto

    initial
    begin
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        t_powerup();
        t_rw();
        t_sw();
        t_hw();
        t_auto();
        complete_run();
    end

    initial
    begin
        #200000;
        err_total++;
        complete_run();
    end
endmodule : nvs_host_tb
